// File: ddl_pkg.sv
// package for the dual data loopback and led control block
// assumes a 100 MHz pclk and an apb master for register access
// Summary of operation
// R1: led one dark unassigned, steady when assigned, flashing on controller or button loopback
// R2: serial rear card: led two flashes only while network codes are received
// R3: office rear card: led two dark on carrier fail, lit when line signal present
// R4: office rear card: led two flashes on network codes or controller loopback
// R5: each button press toggles local digital loopback on and off
// R6: local digital loopback loops both toward the ds0 and the channel side
// R7: requests come from button, controller and three kinds of network code
// R8: loopback performed depends on fitted rear card type
// R9: serial rear card: every request gives local digital loopback
// R10: office rear card: button gives local loop; codes give matching rear loopback
// R11: line side loopback only from controller, works without ds0 assignment
// R12: office unit loopback returns the data signal toward the t1 ds0
// R13: channel service loopback requested by reversing sealing current polarity
// R14: data service loopback requested by sending a control code toward far end
// R15: controller offers full set from test menu, timeslot menu only local loop
// R16: controller assigns each channel to a span and one ds0 slot
// R17: serial card codes activate local loop; office card codes pass to rear card
// R18: flashing leds toggle near two hertz and override steady states
// R19: code-driven loopback ends as soon as the code is no longer detected
package ddl_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned FLASH_HZ = 2;
  // half period of the flash, in cycles
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
  localparam int unsigned NCH = 2;
  // register byte offsets
  localparam logic [11:0] OFS_CFG = 12'h000;
  localparam logic [11:0] OFS_CH0 = 12'h004;
  localparam logic [11:0] OFS_CH1 = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00c;
  // channel control register fields
  localparam int unsigned F_ASSIGNED = 0;
  localparam int unsigned F_SPAN = 1;
  localparam int unsigned F_SLOT_LO = 2;
  localparam int unsigned F_SLOT_W = 5;
  localparam int unsigned F_MGMT_LDL = 8;
  localparam int unsigned F_MGMT_QLB = 9;
  localparam int unsigned F_MGMT_OCU = 10;
  localparam int unsigned F_MGMT_CSU = 11;
  localparam int unsigned F_MGMT_DSU = 12;
  localparam logic [31:0] CH_RST = 32'h0000_0000;
  // cfg register: bit 0 selects office rear card
  localparam int unsigned F_REAR_OFFICE = 0;
  localparam logic [4:0] SLOT_MAX = 5'h17;
  typedef enum logic {DDL_REAR_SERIAL, DDL_REAR_OFFICE} ddl_rear_t;
endpackage : ddl_pkg

// File: ddl_flash.sv
// flash enable divider: square wave at roughly two hertz
// assumes the single system clock pclk
`timescale 1ns/1ps
module ddl_flash
  import ddl_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // flash phase
  output logic flash_q
);
  logic [26:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 27'h0;
      flash_q <= 1'b0;
    end
    else if (cnt_q == 27'(FLASH_HALF_CYC - 1))
    begin
      cnt_q <= 27'h0;
      flash_q <= ~flash_q; // [R18]
    end
    else
    begin
      cnt_q <= cnt_q + 27'h1;
    end
  end
endmodule : ddl_flash

// File: ddl_chan.sv
// per channel loopback routing and led selection
// assumes synchronous inputs and a shared flash phase
`timescale 1ns/1ps
module ddl_chan
  import ddl_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  input wire logic rear_office,
  input wire logic assigned,
  input wire logic mgmt_ldl,
  input wire logic mgmt_qlb,
  input wire logic mgmt_ocu,
  input wire logic mgmt_csu,
  input wire logic mgmt_dsu,
  // events and line state
  input wire logic button_pulse,
  input wire logic rx_office_code,
  input wire logic rx_channel_code,
  input wire logic rx_data_code,
  input wire logic line_signal,
  input wire logic flash,
  // loopback controls
  output logic ldl_t1_q,
  output logic ldl_chan_q,
  output logic qlb_q,
  output logic ocu_lb_q,
  output logic seal_rev_q,
  output logic dsu_code_q,
  output logic pb_ldl_q,
  // leds
  output logic led1_q,
  output logic led2_q
);
  logic any_code;
  logic mgmt_any;
  logic ldl_d;
  logic led1_d;
  logic led2_d;

  assign any_code = rx_office_code | rx_channel_code | rx_data_code; // [R7]
  assign mgmt_any = mgmt_ldl | mgmt_qlb | mgmt_ocu | mgmt_csu | mgmt_dsu;

  // button toggles local loop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pb_ldl_q <= 1'b0;
    else if (button_pulse)
      pb_ldl_q <= ~pb_ldl_q; // [R5]
  end

  always_comb
  begin
    // serial card: every source gives local loop; codes only while present
    if (rear_office == DDL_REAR_SERIAL)
      ldl_d = pb_ldl_q | mgmt_any | any_code; // [R9] [R17] [R19] [R8]
    else
      ldl_d = pb_ldl_q | mgmt_ldl; // [R10]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ldl_t1_q <= 1'b0;
      ldl_chan_q <= 1'b0;
      qlb_q <= 1'b0;
      ocu_lb_q <= 1'b0;
      seal_rev_q <= 1'b0;
      dsu_code_q <= 1'b0;
    end
    else
    begin
      ldl_t1_q <= ldl_d; // [R6]
      ldl_chan_q <= ldl_d; // [R6]
      qlb_q <= rear_office & mgmt_qlb; // [R11]
      ocu_lb_q <= rear_office & (rx_office_code | mgmt_ocu); // [R12] [R10] [R17]
      seal_rev_q <= rear_office & (rx_channel_code | mgmt_csu); // [R13] [R10]
      dsu_code_q <= rear_office & (rx_data_code | mgmt_dsu); // [R14] [R10]
    end
  end

  always_comb
  begin
    if (pb_ldl_q | mgmt_any)
      led1_d = flash; // [R1] [R18]
    else
      led1_d = assigned; // [R1]
    if (rear_office == DDL_REAR_SERIAL)
      led2_d = any_code & flash; // [R2]
    else if (any_code | mgmt_any)
      led2_d = flash; // [R4] [R18]
    else
      led2_d = line_signal; // [R3]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led1_q <= 1'b0;
      led2_q <= 1'b0;
    end
    else
    begin
      led1_q <= led1_d;
      led2_q <= led2_d;
    end
  end
endmodule : ddl_chan

// File: ddl_top.sv
// dual data card loopback and led control, apb register slave
// assumes apb master on pclk; button and code inputs synchronous to pclk
`timescale 1ns/1ps
module ddl_top
  import ddl_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // per channel inputs
  input wire logic [NCH-1:0] front_panel_pushbutton,
  input wire logic [NCH-1:0] office_unit_loopback_code,
  input wire logic [NCH-1:0] channel_service_loopback_code,
  input wire logic [NCH-1:0] data_service_loopback_code,
  input wire logic [NCH-1:0] line_signal_detect,
  // per channel outputs
  output logic [NCH-1:0] local_digital_loopback_t1,
  output logic [NCH-1:0] local_digital_loopback_chan,
  output logic [NCH-1:0] line_side_loopback,
  output logic [NCH-1:0] office_unit_loopback,
  output logic [NCH-1:0] sealing_reverse,
  output logic [NCH-1:0] data_service_code_send,
  output logic [NCH-1:0] led_status,
  output logic [NCH-1:0] led_line
);
  logic cfg_q;
  logic [31:0] ch_q [NCH];
  logic [NCH-1:0] pb_prev_q;
  logic [NCH-1:0] pb_ldl;
  logic flash;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = (paddr == OFS_CFG) | (paddr == OFS_CH0) | (paddr == OFS_CH1)
                   | (paddr == OFS_STAT);
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= 1'b0;
    else if (wr_en && paddr == OFS_CFG)
      cfg_q <= pwdata[F_REAR_OFFICE]; // [R8]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pb_prev_q <= '0;
    else
      pb_prev_q <= front_panel_pushbutton;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        OFS_CFG: prdata <= {31'h0, cfg_q};
        OFS_CH0: prdata <= ch_q[0];
        OFS_CH1: prdata <= ch_q[1];
        OFS_STAT: prdata <= {24'h0, led_line, led_status, local_digital_loopback_t1,
                             pb_ldl};
        default: prdata <= 32'h0;
      endcase
    end
  end

  ddl_flash u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .flash_q(flash)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ch_q[g] <= CH_RST;
        else if (wr_en && paddr == (g == 0 ? OFS_CH0 : OFS_CH1))
        begin
          // slot above the last ds0 is refused; field keeps its value
          ch_q[g] <= {19'h0, pwdata[12:8], 1'b0,
                      (pwdata[6:2] > SLOT_MAX) ? ch_q[g][6:2] : pwdata[6:2],
                      pwdata[1:0]}; // [R16] [R15]
        end
      end

      ddl_chan u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .rear_office(cfg_q),
        .assigned(ch_q[g][F_ASSIGNED]),
        .mgmt_ldl(ch_q[g][F_MGMT_LDL]),
        .mgmt_qlb(ch_q[g][F_MGMT_QLB]),
        .mgmt_ocu(ch_q[g][F_MGMT_OCU]),
        .mgmt_csu(ch_q[g][F_MGMT_CSU]),
        .mgmt_dsu(ch_q[g][F_MGMT_DSU]),
        .button_pulse(front_panel_pushbutton[g] & ~pb_prev_q[g]),
        .rx_office_code(office_unit_loopback_code[g]),
        .rx_channel_code(channel_service_loopback_code[g]),
        .rx_data_code(data_service_loopback_code[g]),
        .line_signal(line_signal_detect[g]),
        .flash(flash),
        .ldl_t1_q(local_digital_loopback_t1[g]),
        .ldl_chan_q(local_digital_loopback_chan[g]),
        .qlb_q(line_side_loopback[g]),
        .ocu_lb_q(office_unit_loopback[g]),
        .seal_rev_q(sealing_reverse[g]),
        .dsu_code_q(data_service_code_send[g]),
        .pb_ldl_q(pb_ldl[g]),
        .led1_q(led_status[g]),
        .led2_q(led_line[g])
      );
    end
  endgenerate
endmodule : ddl_top

// File: ddl_far_model.sv
// far-end service unit and four-wire line behind the rear outputs
// assumes carrier_on comes from the bench, one bit per channel
`timescale 1ns/1ps
module ddl_far_model
  import ddl_pkg::*;
(
  // clock
  input wire logic pclk,
  // line control
  input wire logic [NCH-1:0] carrier_on,
  input wire logic [NCH-1:0] seal_rev,
  input wire logic [NCH-1:0] code_send,
  // line state
  output logic [NCH-1:0] line_sig,
  output logic [NCH-1:0] far_loop
);
  always_ff @(posedge pclk)
  begin
    line_sig <= carrier_on;
    // far unit loops on reversed sealing current or a received code
    far_loop <= seal_rev | code_send;
  end
endmodule : ddl_far_model

// File: ddl_top_sva.sv
// port checker for ddl_top, channel zero shown in detail
// assumes apb writes land at the access edge
`timescale 1ns/1ps
module ddl_top_sva
  import ddl_pkg::*;
(
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // channel inputs
  input wire logic [NCH-1:0] office_unit_loopback_code,
  input wire logic [NCH-1:0] channel_service_loopback_code,
  input wire logic [NCH-1:0] data_service_loopback_code,
  input wire logic [NCH-1:0] line_signal_detect,
  // channel outputs
  input wire logic [NCH-1:0] local_digital_loopback_t1,
  input wire logic [NCH-1:0] local_digital_loopback_chan,
  input wire logic [NCH-1:0] line_side_loopback,
  input wire logic [NCH-1:0] office_unit_loopback,
  input wire logic [NCH-1:0] sealing_reverse,
  input wire logic [NCH-1:0] data_service_code_send,
  input wire logic [NCH-1:0] led_line
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rear_q;
  logic rear_d1_q;
  logic [12:0] ch0_q;
  wire wr = psel && penable && pwrite;
  wire ser = !rear_q && !rear_d1_q;
  wire off = rear_q && rear_d1_q;
  wire cd0 = office_unit_loopback_code[0] | channel_service_loopback_code[0]
    | data_service_loopback_code[0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rear_q <= 1'b0;
      rear_d1_q <= 1'b0;
      ch0_q <= '0;
    end
    else
    begin
      rear_d1_q <= rear_q;
      if (wr && paddr == OFS_CFG)
        rear_q <= pwdata[F_REAR_OFFICE];
      if (wr && paddr == OFS_CH0)
        ch0_q <= pwdata[12:0];
    end
  end
  a_ldl_both_dirs: assert property (
    local_digital_loopback_t1 == local_digital_loopback_chan) else $error("ldl split");
  a_serial_code_ldl: assert property (
    ser && $past(cd0) |-> local_digital_loopback_t1[0]) else $error("code no ldl");
  a_serial_no_rear: assert property (ser |-> line_side_loopback == 0 &&
    office_unit_loopback == 0 && sealing_reverse == 0) else $error("rear lb serial");
  a_office_csu_pass: assert property (
    off && $past(channel_service_loopback_code[0]) |-> sealing_reverse[0])
    else $error("no seal reverse");
  a_office_dsu_pass: assert property (
    off && $past(data_service_loopback_code[0]) |-> data_service_code_send[0])
    else $error("no dsu code");
  a_office_ocu_pass: assert property (
    off && $past(office_unit_loopback_code[0]) |-> office_unit_loopback[0])
    else $error("no ocu lb");
  a_code_release: assert property (off && !$past(channel_service_loopback_code[0])
    && !ch0_q[11] && !$past(ch0_q[11]) |-> !sealing_reverse[0]) else $error("held");
  a_qlb_unassigned: assert property (
    off && ch0_q[9] && $past(ch0_q[9]) |-> line_side_loopback[0]) else $error("no qlb");
  a_line_led: assert property (off && ch0_q[12:8] == 0 && $past(ch0_q[12:8]) == 0
    && !$past(cd0) |-> led_line[0] == $past(line_signal_detect[0])) else $error("led2");
  c_office_seal: cover property (off && sealing_reverse[0]);
  c_serial_ldl: cover property (ser && local_digital_loopback_t1[0]);
  c_qlb: cover property (off && line_side_loopback[0]);
endmodule : ddl_top_sva

// File: ddl_top_tb_top.sv
// self-checking bench for ddl_top with a reference model
// assumes the flash phase stays dark during this short run
`timescale 1ns/1ps
module ddl_top_tb_top
  import ddl_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rear, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] ch [NCH];
  logic [NCH-1:0] pb, oc, cs, ds, car, lsd, t1, tc, q, ou, sr, dc, l1, l2, pbst, m, fl;
  int fail_count, num_checks, seed;
  logic [4:0] mg;
  always #5 pclk = ~pclk;
  ddl_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .front_panel_pushbutton(pb), .office_unit_loopback_code(oc),
    .channel_service_loopback_code(cs), .data_service_loopback_code(ds),
    .line_signal_detect(lsd), .local_digital_loopback_t1(t1),
    .local_digital_loopback_chan(tc), .line_side_loopback(q), .office_unit_loopback(ou),
    .sealing_reverse(sr), .data_service_code_send(dc), .led_status(l1), .led_line(l2));
  ddl_far_model i_far (.pclk(pclk), .carrier_on(car), .seal_rev(sr), .code_send(dc),
    .line_sig(lsd), .far_loop(fl));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle so the next setup never overwrites the release in one step
    @(posedge pclk);
  endtask : apb
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [7:0] expv(int c);
    logic [4:0] k;
    logic ld, s1, ac;
    k = ch[c][12:8];
    ac = oc[c] | cs[c] | ds[c];
    s1 = (pbst[c] || k != 0) ? 1'b0 : ch[c][0];
    if (!rear)
      return {{2{pbst[c] | (k != 0) | ac}}, 4'h0, s1, 1'b0};
    ld = pbst[c] | k[0];
    return {ld, ld, k[1], k[2] | oc[c], k[3] | cs[c], k[4] | ds[c], s1,
      (ac || k != 0) ? 1'b0 : car[c]};
  endfunction : expv
  task final_report();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  initial
  begin
    #100000;
    fail_count++;
    $display("BAD %0t timeout", $time);
    final_report();
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pb, oc, cs, ds, car, pbst} = '0;
    seed = 32'had8248d5;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CH0, 32'h0);
    check(r, CH_RST);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    // slot above the last ds0 is refused and the slot field keeps its value
    apb(1'b1, OFS_CH1, 32'h0000_007d);
    apb(1'b0, OFS_CH1, 32'h0);
    check(r, 32'h0000_0001);
    for (int i = 0; i < 40; i++)
    begin
      rear = 1'($random(seed));
      apb(1'b1, OFS_CFG, {31'h0, rear});
      for (int c = 0; c < NCH; c++)
      begin
        mg = (($random(seed) & 3) == 0) ? 5'($random(seed)) : 5'h0;
        ch[c] = {19'h0, mg, 1'b0, 5'(($random(seed) & 32'hffff) % 24), 2'($random(seed))};
        apb(1'b1, 12'h004 << c, ch[c]);
      end
      oc <= NCH'($random(seed) & $random(seed));
      cs <= NCH'($random(seed) & $random(seed));
      ds <= NCH'($random(seed) & $random(seed));
      car <= NCH'($random(seed));
      m = NCH'($random(seed));
      pb <= m;
      repeat (2) @(posedge pclk);
      pb <= '0;
      pbst = pbst ^ m;
      repeat (3) @(posedge pclk);
      for (int c = 0; c < NCH; c++)
      begin
        check({t1[c], tc[c]}, expv(c) >> 6);
        check({q[c], ou[c], sr[c], dc[c]}, 4'(expv(c) >> 2));
        check({l1[c], l2[c]}, 2'(expv(c)));
        check(fl[c], rear & (ch[c][11] | ch[c][12] | cs[c] | ds[c]));
      end
      apb(1'b0, OFS_STAT, 32'h0);
      check(r[1:0], pbst);
    end
    final_report();
  end
endmodule : ddl_top_tb_top
bind ddl_top ddl_top_sva i_sva (.*);
